// *** design/quart_host_map.svh ***
// Offsets, field positions and reset values of the host pin logic
//
// Behaviour
// - One active-high interrupt per channel, separate-strobe mode
// - Interrupt needs enable and condition, plus gate bit unless forced
// - Sources: errors, data ready, tx empty, modem
// - Force input keeps interrupt outputs always driven
// - Force low: gate bit enables each driver
// - Force input pulled low, ignored in combined mode
// - Read strobe fall drives selected register out
// - Write strobe fall loads selected register
// - Combined mode: direction line high reads, low writes
// - Combined mode: channels merged onto low request
// - Reset pin high clears registers and outputs
// - Combined mode inverts reset pin polarity
// - Ring sense rising edge raises modem interrupt
// - Transmit output rests high during reset, idle
`ifndef QUART_HOST_MAP_SVH
`define QUART_HOST_MAP_SVH

// ----------------------------------------------------------------
// Register offsets within a channel
// ----------------------------------------------------------------
`define REG_IER        3'h1
`define REG_ISR        3'h2
`define REG_MCR        3'h4
`define REG_MSR        3'h6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IER_RX_AVAIL   0
`define IER_TX_EMPTY   1
`define IER_RX_ERROR   2
`define IER_MODEM      3
`define MCR_IRQ_GATE   3
`define MSR_RING_DELTA 2
`define MSR_RING_LEVEL 6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IER_RESET      4'h0
`define MCR_RESET      5'h00
`define DATA_RESET     8'h00

`endif

// *** design/quart_host_pins.sv ***
// Host strobe, interrupt and reset pin logic of a four-channel UART
`timescale 1ns/100ps
`include "quart_host_map.svh"
module quart_host_pins
(
  input  wire logic                  clk_sys,             // System clock, 200 MHz
  input  wire logic                  resetn,              // Power-on reset
  input  wire logic                  reset_pin,           // Reset pin, polarity per mode
  input  wire logic                  bus_mode_sel,        // 1 separate strobes, 0 combined
  input  wire logic                  irq_force_continuous, // Force interrupts driven
  input  wire logic                  host_read_strobe_n,  // Read strobe
  input  wire logic                  host_write_strobe_n, // Write strobe or direction line
  input  wire quart_host_pkg::chan_vec_t chan_sel_n,      // Channel selects; bit 0 is CS
  input  wire logic [4:0]            addr,                // Address pins
  input  wire logic [7:0]            data_in,             // Data bus input
  output logic [7:0]                 data_out,            // Data bus output
  output logic                       data_oe,             // Data bus enable
  input  wire quart_host_pkg::chan_vec_t phone_bell_sense_n, // Ring sense pins
  input  wire quart_host_pkg::chan_vec_t rx_pin,          // Serial receive pins
  input  wire quart_host_pkg::chan_vec_t tx_core,         // Transmit data from core
  output quart_host_pkg::chan_vec_t  tx_pin,              // Serial transmit pins
  output quart_host_pkg::chan_vec_t  rx_core,             // Receive data to core
  input  wire quart_host_pkg::chan_vec_t rx_avail,        // Receive data available
  input  wire quart_host_pkg::chan_vec_t tx_empty,        // Transmit holding empty
  input  wire quart_host_pkg::chan_vec_t rx_error,        // Receiver error
  output quart_host_pkg::chan_vec_t  channel_irq_out,     // Channel interrupt level
  output quart_host_pkg::chan_vec_t  channel_irq_oe,      // Channel interrupt enable
  output logic                       irq_req_out,         // Shared request level
  output logic                       irq_req_oe           // Shared request sink enable
);
  import quart_host_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 30;
  logic [SW-1:0] meta_r;
  logic [SW-1:0] sync_r;
  logic          prev_rd_r;
  logic          prev_wr_r;
  logic          prev_cs_r;
  chan_vec_t     prev_ring_r;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r      <= 30'h3fff_ffff;
      sync_r      <= 30'h3fff_ffff;
      prev_rd_r   <= 1'b1;
      prev_wr_r   <= 1'b1;
      prev_cs_r   <= 1'b1;
      prev_ring_r <= 4'hf;
    end
    else
    begin
      meta_r      <= {host_read_strobe_n, host_write_strobe_n, chan_sel_n, addr, data_in,
                      irq_force_continuous, bus_mode_sel, reset_pin, phone_bell_sense_n,
                      rx_pin};
      sync_r      <= meta_r;
      prev_rd_r   <= sync_r[29];
      prev_wr_r   <= sync_r[28];
      prev_cs_r   <= sync_r[24];
      prev_ring_r <= sync_r[7:4];
    end
  end

  logic      s_rd;
  logic      s_wr;
  chan_vec_t s_cs_n;
  logic [4:0] s_addr;
  logic [7:0] s_data;
  logic      s_force;
  logic      s_sep;
  logic      s_rst;
  chan_vec_t s_ring_n;
  chan_vec_t s_rx;
  assign {s_rd, s_wr, s_cs_n, s_addr, s_data, s_force, s_sep, s_rst, s_ring_n, s_rx} = sync_r;

  // ----------------------------------------------------------------
  // Mode, reset and access decode
  // ----------------------------------------------------------------
  logic      pin_rst;
  logic      force_on;
  logic      rd_go;
  logic      wr_go;
  logic      released;
  chan_idx_t acc_chan;
  reg_sel_t  acc_reg;

  // Separate mode uses the lowest active select; combined mode uses A3-A4
  function automatic chan_idx_t pick_chan(input logic sep, input chan_vec_t cs_n,
                                          input logic [1:0] hi);
    chan_idx_t idx;
    idx = hi;
    if (sep)
    begin
      idx = 2'd3;
      for (int i = 3; i >= 0; i--)
        if (!cs_n[i])
          idx = 2'(i);
    end
    return idx;
  endfunction : pick_chan

  assign pin_rst  = s_sep ? s_rst : ~s_rst;
  assign force_on = s_sep & s_force;
  assign acc_chan = pick_chan(s_sep, s_cs_n, s_addr[4:3]);
  assign acc_reg  = s_addr[2:0];
  assign rd_go = s_sep ? (prev_rd_r & ~s_rd & ~(&s_cs_n))
                       : (prev_cs_r & ~s_cs_n[0] & s_wr);
  assign wr_go = s_sep ? (prev_wr_r & ~s_wr & ~(&s_cs_n))
                       : (prev_cs_r & ~s_cs_n[0] & ~s_wr);
  assign released = s_sep ? (s_rd & s_wr) : s_cs_n[0];

  // ----------------------------------------------------------------
  // Per-channel registers
  // ----------------------------------------------------------------
  access_state_t state_r;
  access_state_t state_nxt;
  logic [3:0] ier_r [4];
  logic [4:0] mcr_r [4];
  chan_vec_t  dring_r;
  chan_vec_t  pend;
  chan_vec_t  gate;
  chan_vec_t  ring_rise;
  logic [7:0] rd_val [4];
  logic       wr_hit;
  logic       rd_hit;

  assign wr_hit    = (state_r == ACC_IDLE) & wr_go & ~pin_rst;
  assign rd_hit    = (state_r == ACC_IDLE) & rd_go & ~pin_rst;
  assign ring_rise = s_ring_n & ~prev_ring_r;

  for (genvar c = 0; c < 4; c++)
  begin : g_chan
    logic [3:0] ier_nxt;
    logic [4:0] mcr_nxt;
    logic       dring_nxt;
    logic       sel;

    assign sel = (acc_chan == 2'(c));

    always_comb
    begin
      ier_nxt   = ier_r[c];
      mcr_nxt   = mcr_r[c];
      dring_nxt = dring_r[c] | ring_rise[c];
      if (rd_hit && sel && acc_reg == `REG_MSR)
        dring_nxt = ring_rise[c];
      if (wr_hit && sel && acc_reg == `REG_IER)
        ier_nxt = s_data[3:0];
      if (wr_hit && sel && acc_reg == `REG_MCR)
        mcr_nxt = s_data[4:0];
      if (pin_rst)
      begin
        ier_nxt   = `IER_RESET;
        mcr_nxt   = `MCR_RESET;
        dring_nxt = 1'b0;
      end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
      if (!resetn)
      begin
        ier_r[c]   <= `IER_RESET;
        mcr_r[c]   <= `MCR_RESET;
        dring_r[c] <= 1'b0;
      end
      else
      begin
        ier_r[c]   <= ier_nxt;
        mcr_r[c]   <= mcr_nxt;
        dring_r[c] <= dring_nxt;
      end
    end

    assign pend[c] = (ier_r[c][`IER_RX_AVAIL] & rx_avail[c])
                   | (ier_r[c][`IER_TX_EMPTY] & tx_empty[c])
                   | (ier_r[c][`IER_RX_ERROR] & rx_error[c])
                   | (ier_r[c][`IER_MODEM] & dring_r[c]);
    assign gate[c] = force_on | mcr_r[c][`MCR_IRQ_GATE];

    always_comb
    begin
      rd_val[c] = 8'h00;
      case (acc_reg)
        `REG_IER: rd_val[c] = {4'h0, ier_r[c]};
        `REG_ISR: rd_val[c] = {4'h0, rx_error[c], dring_r[c], tx_empty[c], rx_avail[c]};
        `REG_MCR: rd_val[c] = {3'h0, mcr_r[c]};
        `REG_MSR:
        begin
          rd_val[c][`MSR_RING_LEVEL] = ~s_ring_n[c];
          rd_val[c][`MSR_RING_DELTA] = dring_r[c];
        end
        default:  rd_val[c] = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Access sequencer and pin outputs
  // ----------------------------------------------------------------
  logic [7:0] data_out_nxt;
  logic       data_oe_nxt;
  chan_vec_t  irq_nxt;
  chan_vec_t  irq_oe_nxt;
  logic       req_oe_nxt;
  chan_vec_t  tx_nxt;
  chan_vec_t  rx_nxt;

  always_comb
  begin
    state_nxt    = state_r;
    data_out_nxt = data_out;
    data_oe_nxt  = data_oe;
    case (state_r)
      ACC_IDLE:
      begin
        if (rd_hit)
        begin
          state_nxt    = ACC_READ;
          data_out_nxt = rd_val[acc_chan];
          data_oe_nxt  = 1'b1;
        end
        else if (wr_hit)
          state_nxt = ACC_WRITE;
      end
      ACC_READ, ACC_WRITE:
      begin
        // Hold until the strobe goes away so one edge is one access
        if (released)
        begin
          state_nxt   = ACC_IDLE;
          data_oe_nxt = 1'b0;
        end
      end
      default:
      begin
        state_nxt   = ACC_IDLE;
        data_oe_nxt = 1'b0;
      end
    endcase
    if (pin_rst)
    begin
      state_nxt    = ACC_IDLE;
      data_out_nxt = `DATA_RESET;
      data_oe_nxt  = 1'b0;
    end
    irq_nxt    = s_sep ? (pend & gate) : 4'h0;
    irq_oe_nxt = s_sep ? (force_on ? 4'hf : gate) : 4'h0;
    req_oe_nxt = ~s_sep & (|pend);
    tx_nxt     = tx_core;
    rx_nxt     = s_rx;
    if (pin_rst)
    begin
      irq_nxt    = 4'h0;
      irq_oe_nxt = 4'h0;
      req_oe_nxt = 1'b0;
      tx_nxt     = 4'hf;
      rx_nxt     = 4'hf;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r         <= ACC_IDLE;
      data_out        <= `DATA_RESET;
      data_oe         <= 1'b0;
      channel_irq_out <= 4'h0;
      channel_irq_oe  <= 4'h0;
      irq_req_out     <= 1'b0;
      irq_req_oe      <= 1'b0;
      tx_pin          <= 4'hf;
      rx_core         <= 4'hf;
    end
    else
    begin
      state_r         <= state_nxt;
      data_out        <= data_out_nxt;
      data_oe         <= data_oe_nxt;
      channel_irq_out <= irq_nxt;
      channel_irq_oe  <= irq_oe_nxt;
      irq_req_out     <= 1'b0;
      irq_req_oe      <= req_oe_nxt;
      tx_pin          <= tx_nxt;
      rx_core         <= rx_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_irq_needs_cause: assert property (##1 (channel_irq_out & ~$past(pend & gate)) == 4'h0)
    else $error("channel interrupt without enabled cause and gate");
  a_force_drives_all: assert property (
    (s_sep && s_force && !pin_rst) |=> channel_irq_oe == 4'hf)
    else $error("forced interrupt drivers not all enabled");
  a_gate_tristate: assert property (
    (s_sep && !s_force && !pin_rst) |=> channel_irq_oe == $past(gate))
    else $error("interrupt driver enable does not follow gate bit");
  a_comb_no_chan_irq: assert property (
    !s_sep |=> channel_irq_oe == 4'h0 && channel_irq_out == 4'h0)
    else $error("channel interrupts driven in combined mode");
  a_read_data_out: assert property (
    rd_hit |=> data_oe && data_out == $past(rd_val[acc_chan]) && state_r == ACC_READ)
    else $error("read strobe did not drive selected register");
  a_write_once: assert property (
    ((wr_hit || state_r == ACC_WRITE) && !released && !pin_rst) |=> state_r == ACC_WRITE)
    else $error("write access left before strobe release");
  a_comb_direction: assert property ((!s_sep && rd_hit) |-> s_wr)
    else $error("combined read taken with direction line low");
  a_shared_request: assert property (
    (!s_sep && |pend && !pin_rst) |=> irq_req_oe && !irq_req_out)
    else $error("shared request not pulled low");
  a_reset_outputs: assert property (
    pin_rst |=> tx_pin == 4'hf && channel_irq_oe == 4'h0 && !data_oe)
    else $error("outputs not at rest during reset");
  a_ring_delta: assert property (
    (ring_rise != 4'h0 && !pin_rst) |=> (dring_r & $past(ring_rise)) == $past(ring_rise))
    else $error("ring end edge not latched");

  c_read_done:  cover property (rd_hit ##[1:20] state_r == ACC_IDLE);
  c_write_done: cover property (wr_hit ##1 state_r == ACC_WRITE);
  c_ring_irq:   cover property (ring_rise[1] ##[1:4] channel_irq_out[1]);
  c_shared_req: cover property (!s_sep && irq_req_oe);
endmodule : quart_host_pins

// *** design/quart_host_pkg.sv ***
// Types shared by the host pin logic
package quart_host_pkg;
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_READ  = 2'b01,
    ACC_WRITE = 2'b10
  } access_state_t;
  typedef logic [3:0] chan_vec_t;
  typedef logic [1:0] chan_idx_t;
  typedef logic [2:0] reg_sel_t;
endpackage : quart_host_pkg

// *** test/quart_board_model.sv ***
// Board around the host pins: pull resistors and resolved interrupt wires
`timescale 1ns/100ps
module quart_board_model
(
  input  wire logic                      clk_sys,     // System clock
  input  wire quart_host_pkg::chan_vec_t irq_out,     // Channel interrupt levels
  input  wire quart_host_pkg::chan_vec_t irq_oe,      // Channel interrupt enables
  input  wire logic                      req_out,     // Shared request level
  input  wire logic                      req_oe,      // Shared request sink enable
  input  wire logic                      force_en,    // Host drives the force pin
  input  wire logic                      force_level, // Level while driven
  output quart_host_pkg::chan_vec_t      irq_wire,    // Channel interrupt wires
  output logic                           req_wire,    // Shared request wire
  output logic                           force_pin    // Force select wire
);
  import quart_host_pkg::*;
  chan_vec_t last_r = 4'h0;
  // No pull on channel lines: a released line toggles so it never looks valid
  always_ff @(posedge clk_sys)
  begin
    last_r <= irq_wire;
  end
  assign irq_wire  = (irq_oe & irq_out) | (~irq_oe & ~last_r);
  assign req_wire  = req_oe ? req_out : 1'b1;
  assign force_pin = force_en ? force_level : 1'b0;
endmodule : quart_board_model

// *** test/quart_host_pins_tb.sv ***
// Self-checking bench for the host strobe, interrupt and reset pins
`timescale 1ns/100ps
module quart_host_pins_tb;
  import quart_host_pkg::*;
  logic       clk_sys = 1'b0;
  logic       resetn, reset_pin, bus_mode_sel, force_en, force_level, force_pin;
  logic       host_read_strobe_n, host_write_strobe_n, data_oe, irq_req_out, irq_req_oe;
  logic       req_wire;
  chan_vec_t  chan_sel_n, phone_bell_sense_n, rx_pin, tx_core, tx_pin, rx_core;
  chan_vec_t  rx_avail, tx_empty, rx_error, channel_irq_out, channel_irq_oe, irq_wire;
  logic [4:0] addr;
  logic [7:0] data_in, data_out, rd;
  int         num_errors = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  always #2.5 clk_sys = ~clk_sys;

  quart_host_pins dut (.clk_sys(clk_sys), .resetn(resetn), .reset_pin(reset_pin),
    .bus_mode_sel(bus_mode_sel), .irq_force_continuous(force_pin),
    .host_read_strobe_n(host_read_strobe_n), .host_write_strobe_n(host_write_strobe_n),
    .chan_sel_n(chan_sel_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .phone_bell_sense_n(phone_bell_sense_n), .rx_pin(rx_pin),
    .tx_core(tx_core), .tx_pin(tx_pin), .rx_core(rx_core), .rx_avail(rx_avail),
    .tx_empty(tx_empty), .rx_error(rx_error), .channel_irq_out(channel_irq_out),
    .channel_irq_oe(channel_irq_oe), .irq_req_out(irq_req_out), .irq_req_oe(irq_req_oe));

  quart_board_model board (.clk_sys(clk_sys), .irq_out(channel_irq_out),
    .irq_oe(channel_irq_oe), .req_out(irq_req_out), .req_oe(irq_req_oe),
    .force_en(force_en), .force_level(force_level), .irq_wire(irq_wire),
    .req_wire(req_wire), .force_pin(force_pin));

  task automatic end_of_test();
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One access in either bus mode; strobe held 6 cycles to clear the synchronisers
  task automatic acc(input logic wr, input logic [1:0] ch, input logic [2:0] rg,
                     input logic [7:0] wd);
    @(negedge clk_sys);
    data_in = wd;
    addr = bus_mode_sel ? {2'b00, rg} : {ch, rg};
    chan_sel_n = bus_mode_sel ? ~(4'h1 << ch) : 4'hf;
    if (!bus_mode_sel)
      host_write_strobe_n = ~wr;
    @(negedge clk_sys);
    if (!bus_mode_sel)
      chan_sel_n[0] = 1'b0;
    else if (wr)
      host_write_strobe_n = 1'b0;
    else
      host_read_strobe_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    rd = data_out;
    chk("data_oe", {7'h00, data_oe}, {7'h00, !wr});
    host_read_strobe_n = 1'b1;
    host_write_strobe_n = 1'b1;
    chan_sel_n = 4'hf;
    repeat (6) @(negedge clk_sys);
    chk("data_oe idle", {7'h00, data_oe}, 8'h00);
  endtask : acc

  task automatic rdchk(input string what, input logic [1:0] ch, input logic [2:0] rg,
                       input logic [7:0] exp);
    acc(1'b0, ch, rg, 8'h00);
    chk(what, rd, exp);
  endtask : rdchk

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  initial
  begin
    resetn = 1'b0; reset_pin = 1'b0; bus_mode_sel = 1'b1; force_en = 1'b0;
    force_level = 1'b0; host_read_strobe_n = 1'b1; host_write_strobe_n = 1'b1;
    chan_sel_n = 4'hf; addr = 5'h00; data_in = 8'h00; phone_bell_sense_n = 4'hf;
    rx_pin = 4'ha; tx_core = 4'h5; rx_avail = 4'h0; tx_empty = 4'h0; rx_error = 4'h0;
    repeat (3) @(negedge clk_sys);
    chk("tx_pin", {4'h0, tx_pin}, 8'h0f);
    chk("rx_core", {4'h0, rx_core}, 8'h0f);
    resetn = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("tx_pin", {4'h0, tx_pin}, 8'h05);
    chk("rx_core", {4'h0, rx_core}, 8'h0a);
    acc(1'b1, 2'd0, `REG_MCR, 8'h08);
    rdchk("mcr", 2'd0, `REG_MCR, 8'h08);
    rdchk("ier", 2'd1, `REG_IER, 8'h00);
    // Each of rx_avail, tx_empty, rx_error alone, first with a wrong enable, then its own
    for (int i = 0; i < 3; i++)
    begin
      rx_avail[0] = (i == 0);
      tx_empty[0] = (i == 1);
      rx_error[0] = (i == 2);
      acc(1'b1, 2'd0, `REG_IER, 8'h01 << ((i + 1) % 3));
      chk("irq off", {4'h0, channel_irq_out}, 8'h00);
      acc(1'b1, 2'd0, `REG_IER, 8'h01 << i);
      chk("irq on", {4'h0, channel_irq_out}, 8'h01);
    end
    rdchk("ier", 2'd0, `REG_IER, 8'h04);
    rdchk("isr", 2'd0, `REG_ISR, 8'h08);
    chk("irq oe", {4'h0, channel_irq_oe}, 8'h01);
    chk("irq wire", {7'h00, irq_wire[0]}, 8'h01);
    acc(1'b1, 2'd0, `REG_MCR, 8'h00);
    chk("irq oe", {4'h0, channel_irq_oe}, 8'h00);
    chk("irq out", {4'h0, channel_irq_out}, 8'h00);
    force_en = 1'b1;
    force_level = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk("irq oe", {4'h0, channel_irq_oe}, 8'h0f);
    chk("irq out", {4'h0, channel_irq_out}, 8'h01);
    force_en = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk("irq oe", {4'h0, channel_irq_oe}, 8'h00);
    // Ring: only the release edge interrupts
    acc(1'b1, 2'd1, `REG_IER, 8'h08);
    acc(1'b1, 2'd1, `REG_MCR, 8'h08);
    phone_bell_sense_n[1] = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk("ring fall", {4'h0, channel_irq_out}, 8'h00);
    phone_bell_sense_n[1] = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk("ring rise", {4'h0, channel_irq_out}, 8'h02);
    acc(1'b0, 2'd1, `REG_MSR, 8'h00);
    chk("ring delta", rd & 8'h04, 8'h04);
    chk("ring clear", {4'h0, channel_irq_out}, 8'h00);
    reset_pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("tx_pin", {4'h0, tx_pin}, 8'h0f);
    chk("irq oe", {4'h0, channel_irq_oe}, 8'h00);
    reset_pin = 1'b0;
    repeat (5) @(negedge clk_sys);
    rdchk("ier", 2'd0, `REG_IER, 8'h00);
    // Combined mode: reset pin now active low
    bus_mode_sel = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("tx_pin", {4'h0, tx_pin}, 8'h0f);
    reset_pin = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk("tx_pin", {4'h0, tx_pin}, 8'h05);
    force_en = 1'b1;
    acc(1'b1, 2'd2, `REG_IER, 8'h02);
    rdchk("ier", 2'd2, `REG_IER, 8'h02);
    chk("req idle", {7'h00, req_wire}, 8'h01);
    tx_empty[2] = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("req", {7'h00, req_wire}, 8'h00);
    chk("irq oe", {4'h0, channel_irq_oe}, 8'h00);
    tx_empty[2] = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("req", {7'h00, req_wire}, 8'h01);
    end_of_test();
  end
endmodule : quart_host_pins_tb
